/* File: bench/core_ctx_model.sv */
// Far-side model: the core's context registers as the unit sees them.
// Assumes restoreValid is a one-cycle pulse that the core must take at once.
`timescale 1ns/100ps
`default_nettype none

module core_ctx_model (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic ctxLoad,
	input wire pc_shadow_pkg::core_ctx_t ctxIn,
	input wire logic restoreValid,
	input wire pc_shadow_pkg::core_ctx_t restoreCtx,
	output pc_shadow_pkg::core_ctx_t curCtx
);
	// Restore beats an ordinary update, since the pulse stands one cycle only
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			curCtx <= pc_shadow_pkg::CTX_RESET;
		end else if (restoreValid) begin
			curCtx <= restoreCtx;
		end else if (ctxLoad) begin
			curCtx <= ctxIn;
		end
	end
endmodule : core_ctx_model
`default_nettype wire

/* File: bench/tb_pc_shadow_unit.sv */
// Self-checking bench for the program counter and shadow context unit.
// Assumes strobes are driven 1 ns after each rising edge of core_clk.
`timescale 1ns/100ps
`default_nettype none

module tb_pc_shadow_unit;
	logic core_clk, resetn;
	logic [9:0] stb; // ctx, uw, hw, lr, lw, fr, vt, fc, dl, adv
	logic [20:0] addrIn;
	logic [7:0] dataIn, lowReadData, pcHighLatch, mHl, mLrd;
	logic [4:0] pcUpperLatch, mUl;
	logic [20:0] pcAddr, mPc;
	logic restoreValid;
	pc_shadow_pkg::core_ctx_t curCtx, restoreCtx, mSh;
	logic [41:0] pcQ[$]; // Expected pc, latches, read byte
	pc_shadow_pkg::core_ctx_t restQ[$]; // Expected restored context
	logic [41:0] note;
	int nMismatch = 0, testsRun = 0, cycles = 0;
	int seed = 32'hcad84ec2;

	// Free-running core clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	pc_shadow_unit i_dut (.core_clk(core_clk), .resetn(resetn),
		.advance(stb[0]), .directLoad(stb[1]), .directTarget(addrIn),
		.fastCall(stb[2]), .vectorTake(stb[3]), .vectorAddr(~addrIn),
		.fastReturn(stb[4]), .lowWrite(stb[5]), .lowWriteData(dataIn),
		.lowRead(stb[6]), .highLatchWrite(stb[7]), .upperLatchWrite(stb[8]),
		.latchWriteData(dataIn), .curCtx(curCtx), .pcAddr(pcAddr),
		.lowReadData(lowReadData), .pcHighLatch(pcHighLatch),
		.pcUpperLatch(pcUpperLatch), .restoreValid(restoreValid),
		.restoreCtx(restoreCtx));

	core_ctx_model i_ctx (.core_clk(core_clk), .resetn(resetn),
		.ctxLoad(stb[9]), .ctxIn({dataIn, dataIn ^ 8'h5a, ~dataIn}),
		.restoreValid(restoreValid), .restoreCtx(restoreCtx),
		.curCtx(curCtx));

	// One compare, counted; mismatches reported at once
	task automatic chk(input string nm, input logic [23:0] e,
		input logic [23:0] g);
		testsRun++;
		if (g !== e) begin
			nMismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Drive one cycle of strobes and note what must follow the edge
	task automatic cyc(input logic [9:0] s, input logic [20:0] a,
		input logic [7:0] d);
		logic [20:0] nPc;
		stb = s;
		addrIn = a;
		dataIn = d;
		nPc = mPc;
		if (s[3])
			nPc = {~a[20:1], 1'b0};
		else if (s[1])
			nPc = {a[20:1], 1'b0};
		else if (s[5])
			nPc = {mUl, mHl, d[7:1], 1'b0};
		else if (s[0])
			nPc = mPc + 21'h000002;
		if (s[6]) begin
			mHl = mPc[15:8];
			mUl = mPc[20:16];
			mLrd = mPc[7:0];
		end else begin
			if (s[7])
				mHl = d;
			if (s[8])
				mUl = d[4:0];
		end
		// Restore hands back the entry held before this edge
		if (s[4])
			restQ.push_back(mSh);
		if (s[3] || (s[1] && s[2]))
			mSh = curCtx;
		mPc = nPc;
		@(posedge core_clk);
		pcQ.push_back({mPc, mHl, mUl, mLrd});
		#1;
	endtask : cyc

	// Watcher: takes the oldest note whenever a result is due
	always @(negedge core_clk) begin
		if (pcQ.size() > 0) begin
			note = pcQ.pop_front();
			chk("pcAddr", {3'h0, note[41:21]}, {3'h0, pcAddr});
			chk("pcHighLatch", {16'h0, note[20:13]}, {16'h0, pcHighLatch});
			chk("pcUpperLatch", {19'h0, note[12:8]}, {19'h0, pcUpperLatch});
			chk("lowReadData", {16'h0, note[7:0]}, {16'h0, lowReadData});
		end
		if (restoreValid === 1'b1) begin
			if (restQ.size() == 0)
				chk("restoreValid", 24'h0, 24'h1);
			else
				chk("restoreCtx", restQ.pop_front(), restoreCtx);
		end else if (restoreValid !== 1'b0) begin
			chk("restoreValid", 24'h0, {23'h0, restoreValid});
		end
	end

	// Verdict, reached from the main sequence or the hang guard
	task automatic completeRun();
		$display("Compares %0d mismatches %0d", testsRun, nMismatch);
		if (nMismatch == 0 && testsRun > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : completeRun

	// Hang guard: the whole run needs well under 1000 cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 2000) begin
			nMismatch++;
			$display("Error timeout expected end seen none");
			completeRun();
		end
	end

	initial begin
		stb = '0;
		addrIn = '0;
		dataIn = '0;
		resetn = 1'b0;
		{mPc, mHl, mUl, mLrd} = '0;
		mSh = pc_shadow_pkg::CTX_RESET;
		repeat (8) @(posedge core_clk);
		#1;
		resetn = 1'b1;
		cyc(10'h000, '0, '0);
		$display("Test reset done");
		// Latches, loads that skip them, wrap of the advance
		cyc(10'h080, '0, 8'h9c);
		cyc(10'h100, '0, 8'h1f);
		cyc(10'h002, 21'h1abcd7, '0);
		cyc(10'h001, '0, '0);
		cyc(10'h002, 21'h1fffff, '0);
		cyc(10'h001, '0, '0);
		cyc(10'h021, '0, 8'h35);
		cyc(10'h0c0, '0, 8'haa);
		cyc(10'h020, '0, 8'hff);
		cyc(10'h00b, 21'h000101, '0);
		$display("Test counter done");
		// Fast call and return, then nested vectoring
		cyc(10'h200, '0, 8'h11);
		cyc(10'h006, 21'h000400, '0);
		cyc(10'h200, '0, 8'h22);
		cyc(10'h010, '0, '0);
		cyc(10'h200, '0, 8'h33);
		// Nested vectoring overwrites the context saved for the low handler
		cyc(10'h008, 21'h1fffe7, '0);
		cyc(10'h200, '0, 8'h44);
		cyc(10'h008, 21'h1ffff7, '0);
		cyc(10'h010, '0, '0);
		cyc(10'h018, 21'h1ffff7, '0);
		cyc(10'h000, '0, '0);
		$display("Test shadow done");
		// Random strobe mixes exercise the priorities
		repeat (300) begin
			cyc(10'($random(seed)), 21'($random(seed)), 8'($random(seed)));
		end
		cyc(10'h000, '0, '0);
		cyc(10'h000, '0, '0);
		// Let the watcher take the last note before the verdict
		@(negedge core_clk);
		#1;
		chk("restorePending", 24'h0, 24'(restQ.size()));
		$display("Test random done");
		completeRun();
	end
endmodule : tb_pc_shadow_unit
`default_nettype wire

/* File: inc/pc_shadow_pkg.sv */
// Package for the program counter and shadow context block.
// Assumes an 8-bit core whose decoder issues one-cycle operation strobes.
package pc_shadow_pkg;

	// Program counter geometry
	localparam int PC_WIDTH = 21;
	localparam int BYTE_W = 8;
	localparam int HIGH_LSB = 8;
	localparam int UPPER_LSB = 16;

	// Sequential advance, one instruction word of two bytes
	localparam logic [PC_WIDTH-1:0] PC_STEP = 21'h000002;

	// Reset values
	localparam logic [PC_WIDTH-1:0] PC_RESET = 21'h000000;
	localparam logic [BYTE_W-1:0] LATCH_RESET = 8'h00;
	localparam logic [BYTE_W-1:0] CTX_FIELD_RESET = 8'h00;

	// Word alignment: the low address bit is forced to this value
	localparam logic PC_ALIGN_BIT = 1'b0;

	// Context saved by the shadow slot
	typedef struct packed {
		logic [BYTE_W-1:0] status;
		logic [BYTE_W-1:0] workingRegister;
		logic [BYTE_W-1:0] bankSelectRegister;
	} core_ctx_t;

	localparam core_ctx_t CTX_RESET = '{
		status: CTX_FIELD_RESET,
		workingRegister: CTX_FIELD_RESET,
		bankSelectRegister: CTX_FIELD_RESET
	};

	// Source of the next program counter, in priority order
	typedef enum logic [2:0] {
		SRC_HOLD = 3'h0,
		SRC_ADVANCE = 3'h1,
		SRC_LOW_WRITE = 3'h3,
		SRC_DIRECT = 3'h2,
		SRC_VECTOR = 3'h6
	} pc_src_t;

endpackage : pc_shadow_pkg

/* File: verilog/pc_shadow_unit.sv */
// Program counter with low-byte latch transfer, and one-deep shadow context.
// Assumes one-cycle strobes from the decoder and interrupt logic on core_clk.
//
// Functional notes
// RULE1 - Interrupt vectoring saves status, working, bank registers
// RULE2 - Shadow entry has no software read/write path
// RULE3 - Fast interrupt return restores saved context
// RULE4 - Every interrupt overwrites shadow, nesting loses earlier
// RULE5 - Low priority handlers save registers in software
// RULE6 - Fast call saves context, fast return restores
// RULE7 - Program counter is 21-bit byte address
// RULE8 - Upper counter bits only reachable through latches
// RULE9 - Low byte write loads latches into counter
// RULE10 - Low byte read copies upper counter into latches
// RULE11 - Counter bit zero always reads zero
// RULE12 - Sequential execution advances counter by two
// RULE13 - Calls, jumps, branches load counter, skip latches
`timescale 1ns/100ps
`default_nettype none

module pc_shadow_unit #(
	parameter int PC_WIDTH = pc_shadow_pkg::PC_WIDTH
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic advance,
	input wire logic directLoad,
	input wire logic [PC_WIDTH-1:0] directTarget,
	input wire logic fastCall,
	input wire logic vectorTake,
	input wire logic [PC_WIDTH-1:0] vectorAddr,
	input wire logic fastReturn,
	input wire logic lowWrite,
	input wire logic [7:0] lowWriteData,
	input wire logic lowRead,
	input wire logic highLatchWrite,
	input wire logic upperLatchWrite,
	input wire logic [7:0] latchWriteData,
	input wire pc_shadow_pkg::core_ctx_t curCtx,
	output logic [PC_WIDTH-1:0] pcAddr,
	output logic [7:0] lowReadData,
	output logic [7:0] pcHighLatch,
	output logic [PC_WIDTH-17:0] pcUpperLatch,
	output logic restoreValid,
	output pc_shadow_pkg::core_ctx_t restoreCtx
);

	localparam int UPPER_W = PC_WIDTH - pc_shadow_pkg::UPPER_LSB;
	localparam int CTX_W = $bits(pc_shadow_pkg::core_ctx_t);

	// The latch split needs a full high byte and at most a byte above it
	if (PC_WIDTH <= pc_shadow_pkg::UPPER_LSB || PC_WIDTH > 24) begin : g_chk
		$error("pc_shadow_unit: PC_WIDTH must be 17 to 24");
	end

	// Program counter state
	logic [PC_WIDTH-1:0] pc_r; // Fetch byte address
	logic [PC_WIDTH-1:0] pc_nxt;
	pc_shadow_pkg::pc_src_t pcSrc; // Chosen source this cycle

	// Latch and readback state
	logic [7:0] latchHigh_r; // Staging for counter bits 15..8
	logic [7:0] latchHigh_nxt;
	logic [UPPER_W-1:0] latchUpper_r; // Staging for bits above 15
	logic [UPPER_W-1:0] latchUpper_nxt;
	logic [7:0] lowRead_r; // Low byte as last read
	logic [7:0] lowRead_nxt;

	// Restore state
	logic restoreValid_r; // One-cycle restore strobe
	logic restoreValid_nxt;
	pc_shadow_pkg::core_ctx_t restoreCtx_r; // Context to write back
	pc_shadow_pkg::core_ctx_t restoreCtx_nxt;

	// Shadow slot wiring
	logic shadowSave; // Save strobe into the slot
	logic [CTX_W-1:0] shadowQ; // Held entry
	pc_shadow_pkg::core_ctx_t shadowCtx;

	// Save on every vectoring, whatever its priority, and on fast call.
	// Nested vectoring simply overwrites; handlers at low priority
	// cannot rely on the slot when both priorities are live.
	always_comb begin
		shadowSave = vectorTake | (directLoad & fastCall); // see RULE1 RULE4
	end

	// Slot has no port other than save and the restore path here
	shadow_slot #(
		.WIDTH(CTX_W)
	) u_shadow (
		.core_clk(core_clk),
		.resetn(resetn),
		.load(shadowSave), // see RULE6 RULE2
		.loadData(curCtx),
		.slotQ(shadowQ)
	);

	assign shadowCtx = pc_shadow_pkg::core_ctx_t'(shadowQ);

	// Counter source select: vectoring beats direct load, beats low
	// byte write, beats sequential advance
	always_comb begin
		if (vectorTake) begin
			pcSrc = pc_shadow_pkg::SRC_VECTOR;
		end else if (directLoad) begin
			pcSrc = pc_shadow_pkg::SRC_DIRECT;
		end else if (lowWrite) begin
			pcSrc = pc_shadow_pkg::SRC_LOW_WRITE;
		end else if (advance) begin
			pcSrc = pc_shadow_pkg::SRC_ADVANCE;
		end else begin
			pcSrc = pc_shadow_pkg::SRC_HOLD;
		end
	end

	// Next counter value; bit zero is forced on every path so a stray
	// odd target can never misalign fetch
	always_comb begin
		pc_nxt = pc_r;
		case (pcSrc)
			pc_shadow_pkg::SRC_VECTOR: begin
				pc_nxt = vectorAddr;
			end
			pc_shadow_pkg::SRC_DIRECT: begin
				// Latches are not involved
				pc_nxt = directTarget; // see RULE13
			end
			pc_shadow_pkg::SRC_LOW_WRITE: begin
				// Upper bits only ever enter through the latches
				pc_nxt = {latchUpper_r, latchHigh_r, lowWriteData}; // see RULE9 RULE8
			end
			pc_shadow_pkg::SRC_ADVANCE: begin
				pc_nxt = pc_r + PC_WIDTH'(pc_shadow_pkg::PC_STEP); // see RULE12
			end
			default: begin
				pc_nxt = pc_r;
			end
		endcase
		pc_nxt[0] = pc_shadow_pkg::PC_ALIGN_BIT; // see RULE11
	end

	// Counter register
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pc_r <= PC_WIDTH'(pc_shadow_pkg::PC_RESET); // see RULE7
		end else begin
			pc_r <= pc_nxt;
		end
	end

	// Latch next values. A low byte read copies the upper counter bits
	// and wins over a latch write in the same cycle, so a computed
	// offset always starts from the true page.
	always_comb begin
		latchHigh_nxt = latchHigh_r;
		latchUpper_nxt = latchUpper_r;
		lowRead_nxt = lowRead_r;
		if (highLatchWrite) begin
			latchHigh_nxt = latchWriteData;
		end
		if (upperLatchWrite) begin
			latchUpper_nxt = latchWriteData[UPPER_W-1:0];
		end
		if (lowRead) begin
			latchHigh_nxt = pc_r[pc_shadow_pkg::UPPER_LSB-1:
				pc_shadow_pkg::HIGH_LSB]; // see RULE10
			latchUpper_nxt = pc_r[PC_WIDTH-1:pc_shadow_pkg::UPPER_LSB];
			lowRead_nxt = pc_r[pc_shadow_pkg::HIGH_LSB-1:0];
		end
	end

	// Latch registers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			latchHigh_r <= pc_shadow_pkg::LATCH_RESET;
			latchUpper_r <= UPPER_W'(pc_shadow_pkg::LATCH_RESET);
			lowRead_r <= pc_shadow_pkg::LATCH_RESET;
		end else begin
			latchHigh_r <= latchHigh_nxt;
			latchUpper_r <= latchUpper_nxt;
			lowRead_r <= lowRead_nxt;
		end
	end

	// Restore strobe: presents the entry as held before any save in
	// the same cycle, so the core writes back what was stacked
	always_comb begin
		restoreValid_nxt = fastReturn; // see RULE3 RULE6
		restoreCtx_nxt = restoreCtx_r;
		if (fastReturn) begin
			restoreCtx_nxt = shadowCtx;
		end
	end

	// Restore registers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			restoreValid_r <= 1'b0;
			restoreCtx_r <= pc_shadow_pkg::CTX_RESET;
		end else begin
			restoreValid_r <= restoreValid_nxt;
			restoreCtx_r <= restoreCtx_nxt;
		end
	end

	// Outputs straight from registers
	assign pcAddr = pc_r;
	assign lowReadData = lowRead_r;
	assign pcHighLatch = latchHigh_r;
	assign pcUpperLatch = latchUpper_r;
	assign restoreValid = restoreValid_r;
	assign restoreCtx = restoreCtx_r;

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	chk_vector_save: assert property ( // see RULE1 RULE4
		vectorTake |=> shadowQ == $past(curCtx)
	) else $error("shadow not loaded on vectoring");

	chk_fast_call_save: assert property ( // see RULE6
		directLoad && fastCall |=> shadowQ == $past(curCtx)
	) else $error("shadow not loaded on fast call");

	chk_shadow_hold: assert property ( // see RULE2
		!shadowSave |=> shadowQ == $past(shadowQ)
	) else $error("shadow changed without a save");

	chk_fast_restore: assert property ( // see RULE3
		fastReturn |=> restoreValid_r && restoreCtx_r == $past(shadowQ)
	) else $error("fast return did not restore entry");

	chk_restore_quiet: assert property ( // see RULE6
		!fastReturn |=> !restoreValid_r
	) else $error("restore strobe without fast return");

	chk_pc_aligned: assert property ( // see RULE11
		pc_r[0] == pc_shadow_pkg::PC_ALIGN_BIT
	) else $error("counter bit zero not clear");

	chk_low_write_load: assert property ( // see RULE9 RULE8
		lowWrite && !vectorTake && !directLoad |=>
			pc_r == {$past(latchUpper_r), $past(latchHigh_r),
			$past(lowWriteData[7:1]), pc_shadow_pkg::PC_ALIGN_BIT}
	) else $error("low byte write did not take latches");

	chk_low_read_copy: assert property ( // see RULE10
		lowRead |=> latchHigh_r == $past(pc_r[15:8]) &&
			latchUpper_r == $past(pc_r[PC_WIDTH-1:16])
	) else $error("low byte read did not copy upper bits");

	chk_seq_advance: assert property ( // see RULE12 RULE7
		advance && !vectorTake && !directLoad && !lowWrite |=>
			pc_r == $past(pc_r) + PC_WIDTH'(pc_shadow_pkg::PC_STEP)
	) else $error("sequential advance not by two");

	chk_direct_load: assert property ( // see RULE13
		directLoad && !vectorTake ##1 !lowWrite && !advance &&
			!directLoad && !vectorTake |=> pc_r == $past(pc_r)
	) else $error("direct target not held");

	chk_direct_target: assert property ( // see RULE13
		directLoad && !vectorTake |=>
			pc_r[PC_WIDTH-1:1] == $past(directTarget[PC_WIDTH-1:1])
	) else $error("direct load used the latches");

	// Vectoring must take its own address, not the direct target that
	// the decoder may present in the same cycle
	chk_vector_target: assert property ( // see RULE1
		vectorTake |=>
			pc_r[PC_WIDTH-1:1] == $past(vectorAddr[PC_WIDTH-1:1])
	) else $error("vectoring did not load the vector address");

	// Latch and readback checks. A latch write only survives when no
	// read copies the counter in the same cycle.
	chk_low_read_data: assert property ( // see RULE8
		lowRead |=>
			lowRead_r == $past(pc_r[pc_shadow_pkg::HIGH_LSB-1:0])
	) else $error("low byte read data not captured");

	chk_high_latch_write: assert property ( // see RULE8
		highLatchWrite && !lowRead |=> latchHigh_r == $past(latchWriteData)
	) else $error("high latch write lost");

	chk_upper_latch_write: assert property ( // see RULE8
		upperLatchWrite && !lowRead |=>
			latchUpper_r == $past(latchWriteData[UPPER_W-1:0])
	) else $error("upper latch write lost");

	chk_high_latch_quiet: assert property ( // see RULE8
		!lowRead && !highLatchWrite |=> latchHigh_r == $past(latchHigh_r)
	) else $error("high latch changed without access");

	// The core may sample the restore context late; it must not drift
	chk_restore_hold: assert property ( // see RULE3
		!fastReturn |=> restoreCtx_r == $past(restoreCtx_r)
	) else $error("restore context moved without a return");

	cov_vector: cover property (vectorTake);
	cov_call_return: cover property (
		directLoad && fastCall ##[1:20] fastReturn);
	cov_read_write: cover property (lowRead ##[1:8] lowWrite);
	cov_nested: cover property (vectorTake ##[1:20] vectorTake);
	cov_return_save: cover property (fastReturn && vectorTake);

endmodule : pc_shadow_unit
`default_nettype wire

/* File: verilog/shadow_slot.sv */
// Single-entry hidden holding register for the saved core context.
// Assumes load is a one-cycle strobe from the owning block; no other access.
`timescale 1ns/100ps
`default_nettype none

module shadow_slot #(
	parameter int WIDTH = 24
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic load,
	input wire logic [WIDTH-1:0] loadData,
	output logic [WIDTH-1:0] slotQ
);

	logic [WIDTH-1:0] slot_r; // Held copy
	logic [WIDTH-1:0] slot_nxt; // Next copy

	// Load replaces the whole entry; there is no depth to push into
	always_comb begin
		slot_nxt = slot_r;
		if (load) begin
			slot_nxt = loadData;
		end
	end

	// Register only
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			slot_r <= '0;
		end else begin
			slot_r <= slot_nxt;
		end
	end

	assign slotQ = slot_r;

endmodule : shadow_slot
`default_nettype wire
